// ### hdl/pdc_bank.sv
// pdc_bank.sv: playback dsp config and channel enable registers with decoded controls
// assumes a byte-wide register port on sys_clk from the device's control interface
`timescale 1ns/1ps
`default_nettype none
`include "pdc_cfg.svh"

// How it works
// - two-bit filter response, bits 7:6, reset 0
// - highpass code 0 picks programmable filter
// - highpass codes 1-3 pick fixed filters
// - highpass select bits 5:4, reset 1
// - biquad count bits 3:2, reset 2
// - bit 1 set skips volume soft-stepping
// - link clear: each channel own volume
// - link set: all use first volume
// - input enables at bits 7:4
// - output enables at bits 3:0
// - channel enable resets to 0xcc
// - dsp config resets to 0x18
// - playback power up only enabled outputs
// - record power up only enabled inputs
module pdc_bank
    import pdc_pkg::*;
#(
    parameter int CH = 4
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [6:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    output logic      [7:0]    reg_rdata,
    output logic               reg_hit,
    input  wire logic          playback_power_on,
    input  wire logic          record_power_on,
    output var pdc_filt_t      playback_filter_response,
    output var pdc_hpf_t       playback_highpass_select,
    output logic               highpass_programmable,
    output logic      [1:0]    playback_biquad_count,
    output logic               soft_step_active,
    output logic               playback_volume_link,
    output logic      [CH-1:0] volume_from_first,
    output logic      [CH-1:0] input_enable,
    output logic      [CH-1:0] output_enable,
    output logic      [CH-1:0] input_power,
    output logic      [CH-1:0] output_power
);
    logic [7:0] playback_dsp_config_r;
    logic [7:0] channel_enable_config_r;
    logic [7:0] rdata_r;

    // address decode; both registers sit behind the one control port
    wire logic       sel_dsp = (reg_addr == `PDC_ADDR_DSP_CFG);
    wire logic       sel_ch  = (reg_addr == `PDC_ADDR_CHAN_ENABLE);
    wire logic       wr_take = clk_en & reg_wr;
    wire logic       rd_take = clk_en & reg_rd;
    wire logic       wr_dsp  = wr_take & sel_dsp;
    wire logic       wr_ch   = wr_take & sel_ch;

    // a write replaces the whole byte; nothing else moves either register
    wire logic [7:0] playback_dsp_config_nxt   = wr_dsp ? reg_wdata : playback_dsp_config_r;
    wire logic [7:0] channel_enable_config_nxt = wr_ch ? reg_wdata : channel_enable_config_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            playback_dsp_config_r   <= `PDC_RST_DSP_CFG;
            channel_enable_config_r <= `PDC_RST_CHAN_ENABLE;
        end else if (clk_en) begin
            playback_dsp_config_r   <= playback_dsp_config_nxt;
            channel_enable_config_r <= channel_enable_config_nxt;
        end
    end

    // reserved filter code is stored as written; software must avoid it
    // unmapped addresses read as zero and take no write
    wire logic [7:0] rd_mux    = sel_dsp ? playback_dsp_config_r :
                                 (sel_ch ? channel_enable_config_r : 8'h00);
    // a write in the same cycle wins; the read still returns the old byte
    wire logic [7:0] rdata_nxt = rd_take ? rd_mux : rdata_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rdata_r <= 8'h00;
        else if (clk_en) rdata_r <= rdata_nxt;
    end
    assign reg_rdata = rdata_r;
    assign reg_hit   = sel_dsp | sel_ch;

    assign playback_filter_response =
        pdc_filt_t'(playback_dsp_config_r[`PDC_FILT_MSB:`PDC_FILT_LSB]);
    assign playback_highpass_select =
        pdc_hpf_t'(playback_dsp_config_r[`PDC_HPF_MSB:`PDC_HPF_LSB]);
    assign highpass_programmable = (playback_highpass_select == PDC_HPF_PROG);
    assign playback_biquad_count = playback_dsp_config_r[`PDC_BQ_MSB:`PDC_BQ_LSB];
    assign soft_step_active      = ~playback_dsp_config_r[`PDC_SOFT_OFF_BIT];
    assign playback_volume_link  = playback_dsp_config_r[`PDC_LINK_BIT];
    // channel 1 always uses its own volume; link steers the rest regardless of ch1 enable
    assign volume_from_first = {{(CH-1){playback_volume_link}}, 1'b0};
    // bits 7 and 3 are channel 1, so reverse into channel-indexed vectors
    genvar k;
    generate
        for (k = 0; k < CH; k++) begin : g_en
            assign input_enable[k]  = channel_enable_config_r[`PDC_IN_EN_MSB - k];
            assign output_enable[k] = channel_enable_config_r[`PDC_OUT_EN_MSB - k];
        end
    endgenerate

    // power gating is registered: one edge of lag after any control change
    pdc_chan_power #(.N(CH)) u_out_pwr (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .path_on  (playback_power_on),
        .chan_en  (output_enable),
        .chan_pwr (output_power)
    );
    pdc_chan_power #(.N(CH)) u_in_pwr (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .path_on  (record_power_on),
        .chan_en  (input_enable),
        .chan_pwr (input_power)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // a taken write or read to each target, one edge long
    sequence s_wr_dsp;
        wr_dsp;
    endsequence
    sequence s_wr_ch;
        wr_ch;
    endsequence
    sequence s_wr_miss;
        wr_take && !reg_hit;
    endsequence
    sequence s_rd_dsp;
        rd_take && sel_dsp && !reg_wr;
    endsequence
    sequence s_rd_ch;
        rd_take && sel_ch && !reg_wr;
    endsequence
    sequence s_rd_miss;
        rd_take && !reg_hit;
    endsequence
    // two enabled edges in a row, so power follows what was seen one edge earlier
    sequence s_two_live;
        clk_en ##1 clk_en;
    endsequence

    // reset aborts every attempt in flight, so checks restart cleanly after it
    a_dsp_write_kept: assert property (
        s_wr_dsp |=> playback_dsp_config_r == $past(reg_wdata))
        else $error("dsp config did not take written value");
    a_ch_write_kept: assert property (
        s_wr_ch |=> channel_enable_config_r == $past(reg_wdata))
        else $error("channel enable did not take written value");
    a_miss_write_dropped: assert property (
        s_wr_miss |=> $stable(playback_dsp_config_r) && $stable(channel_enable_config_r))
        else $error("unmapped write changed a register");
    a_read_returns: assert property (
        s_rd_dsp |=> reg_rdata == playback_dsp_config_r)
        else $error("read data differs from dsp config");
    a_ch_read_returns: assert property (
        s_rd_ch |=> reg_rdata == channel_enable_config_r)
        else $error("read data differs from channel enable");
    a_miss_read_zero: assert property (
        s_rd_miss |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !rd_take |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_frozen_regs: assert property (
        !clk_en |=> $stable(playback_dsp_config_r) && $stable(channel_enable_config_r)
            && $stable(rdata_r))
        else $error("register changed while clock enable low");
    a_link_routes: assert property (
        playback_volume_link |-> volume_from_first[CH-1:1] == '1 && !volume_from_first[0])
        else $error("linked channels not using first volume");
    a_own_volume: assert property (
        !playback_volume_link |-> volume_from_first == '0)
        else $error("unlinked channel uses first volume");
    a_soft_step: assert property (
        soft_step_active != playback_dsp_config_r[`PDC_SOFT_OFF_BIT])
        else $error("soft-step control inverted");
    a_filt_field: assert property (
        playback_filter_response == playback_dsp_config_r[`PDC_FILT_MSB:`PDC_FILT_LSB])
        else $error("filter response field mismapped");
    a_biquad_field: assert property (
        playback_biquad_count == playback_dsp_config_r[`PDC_BQ_MSB:`PDC_BQ_LSB])
        else $error("biquad count field mismapped");
    a_hpf_prog: assert property (
        highpass_programmable == (playback_dsp_config_r[`PDC_HPF_MSB:`PDC_HPF_LSB] == 2'b00))
        else $error("programmable highpass decode wrong");
    a_hpf_fixed: assert property (
        playback_dsp_config_r[`PDC_HPF_MSB:`PDC_HPF_LSB] != 2'b00 |-> !highpass_programmable)
        else $error("fixed highpass code picks programmable filter");
    a_out_power: assert property (
        s_two_live |-> output_power == ($past(playback_power_on) ? $past(output_enable) : '0))
        else $error("output power does not follow enables");
    a_in_power: assert property (
        s_two_live |-> input_power == ($past(record_power_on) ? $past(input_enable) : '0))
        else $error("input power does not follow enables");
    a_out_off: assert property (
        clk_en && !playback_power_on |=> output_power == '0)
        else $error("output channel powered with path off");
    a_in_off: assert property (
        clk_en && !record_power_on |=> input_power == '0)
        else $error("input channel powered with path off");
    a_frozen_power: assert property (
        !clk_en |=> $stable(input_power) && $stable(output_power))
        else $error("channel power changed while clock enable low");
    a_map_bits: assert property (
        input_enable[0] == channel_enable_config_r[`PDC_IN_EN_MSB]
            && output_enable[0] == channel_enable_config_r[`PDC_OUT_EN_MSB])
        else $error("channel one enable bits mismapped");
    a_map_last: assert property (
        input_enable[CH-1] == channel_enable_config_r[`PDC_IN_EN_LSB]
            && output_enable[CH-1] == channel_enable_config_r[`PDC_OUT_EN_LSB])
        else $error("last channel enable bits mismapped");
endmodule : pdc_bank
`default_nettype wire

// ### hdl/pdc_cfg.svh
// pdc_cfg.svh: offsets, field positions, reset values for the playback dsp / channel enable bank
// assumes nothing; definitions only
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH

`define PDC_ADDR_DSP_CFG      7'h73
`define PDC_ADDR_CHAN_ENABLE  7'h76
`define PDC_RST_DSP_CFG       8'h18
`define PDC_RST_CHAN_ENABLE   8'hcc
`define PDC_FILT_MSB          7
`define PDC_FILT_LSB          6
`define PDC_HPF_MSB           5
`define PDC_HPF_LSB           4
`define PDC_BQ_MSB            3
`define PDC_BQ_LSB            2
`define PDC_SOFT_OFF_BIT      1
`define PDC_LINK_BIT          0
`define PDC_IN_EN_MSB         7
`define PDC_IN_EN_LSB         4
`define PDC_OUT_EN_MSB        3
`define PDC_OUT_EN_LSB        0
`define PDC_FILT_RESERVED     2'h3

`endif

// ### hdl/pdc_chan_power.sv
// pdc_chan_power.sv: per-channel power gating from enable bits and a path power bit
// assumes all inputs come from logic on sys_clk
`timescale 1ns/1ps
`default_nettype none
module pdc_chan_power #(
    parameter int N = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         path_on,
    input  wire logic [N-1:0] chan_en,
    output logic      [N-1:0] chan_pwr
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            // only enabled channels follow the path bit; clearing it drops all
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) chan_pwr[i] <= 1'b0;
                else if (clk_en) chan_pwr[i] <= path_on & chan_en[i];
            end
        end
    endgenerate
endmodule : pdc_chan_power
`default_nettype wire

// ### hdl/pdc_pkg.sv
// pdc_pkg.sv: types shared by the playback dsp / channel enable bank
// assumes nothing; types only, no macros from pdc_cfg.svh
package pdc_pkg;
    typedef enum logic [1:0] {
        PDC_FILT_LINEAR   = 2'b00,
        PDC_FILT_LOW_LAT  = 2'b01,
        PDC_FILT_ULTRA    = 2'b10,
        PDC_FILT_RESERVED = 2'b11
    } pdc_filt_t;
    typedef enum logic [1:0] {
        PDC_HPF_PROG  = 2'b00,
        PDC_HPF_FIX1  = 2'b01,
        PDC_HPF_FIX2  = 2'b10,
        PDC_HPF_FIX3  = 2'b11
    } pdc_hpf_t;
endpackage : pdc_pkg

// ### test/pdc_bank_test.sv
// pdc_bank_test.sv: self-checking bench for the dsp config / channel enable bank
// assumes pdc_pkg compiled first; the bench drives every port at the falling edge
`timescale 1ns/1ps
`default_nettype none
module pdc_bank_test;
    import pdc_pkg::*;
    logic       sys_clk, rst_n, clk_en, reg_wr, reg_rd, reg_hit;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic       playback_power_on, record_power_on, highpass_programmable;
    logic       soft_step_active, playback_volume_link;
    logic [1:0] playback_biquad_count;
    logic [3:0] volume_from_first, input_enable, output_enable, input_power, output_power;
    pdc_filt_t  playback_filter_response;
    pdc_hpf_t   playback_highpass_select;
    int         mismatches, compares;
    pdc_bank #(.CH(4)) i_dut (.sys_clk, .rst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_hit, .playback_power_on, .record_power_on,
        .playback_filter_response, .playback_highpass_select, .highpass_programmable,
        .playback_biquad_count, .soft_step_active, .playback_volume_link,
        .volume_from_first, .input_enable, .output_enable, .input_power, .output_power);
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        rv = reg_rdata;
    endtask : rd
    task automatic t_reset;
        rd(7'h73);
        check("dsp", rv, 8'h18);
        rd(7'h76);
        check("chen", rv, 8'hcc);
        check("filt", playback_filter_response, 8'h00);
        check("hpf", playback_highpass_select, 8'h01);
        check("bq", playback_biquad_count, 8'h02);
        check("soft", soft_step_active, 8'h01);
    endtask : t_reset
    task automatic t_dsp;
        logic [7:0] vals[5] = '{8'h00, 8'h55, 8'haa, 8'hbf, 8'h46};
        foreach (vals[i]) begin
            wr(7'h73, vals[i]);
            check("filt", playback_filter_response, vals[i][7:6]);
            check("hpf", playback_highpass_select, vals[i][5:4]);
            check("prog", highpass_programmable, vals[i][5:4] == 2'h0);
            check("bq", playback_biquad_count, vals[i][3:2]);
            check("soft", soft_step_active, !vals[i][1]);
            check("link", playback_volume_link, vals[i][0]);
            check("vff", volume_from_first, {{3{vals[i][0]}}, 1'b0});
            rd(7'h73);
            check("dsp rd", rv, vals[i]);
        end
    endtask : t_dsp
    task automatic t_both;
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        reg_addr = 7'h73;
        reg_wdata = 8'h21;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        check("wr over rd", reg_rdata, 8'h46);
        rd(7'h73);
        check("dsp rd", rv, 8'h21);
    endtask : t_both
    task automatic t_chen;
        wr(7'h76, 8'h5a);
        check("in_en", input_enable, 8'h0a);
        check("out_en", output_enable, 8'h05);
        playback_power_on = 1'b1;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check("out_pwr", output_power, 8'h05);
        check("in_pwr", input_power, 8'h00);
        playback_power_on = 1'b0;
        record_power_on = 1'b1;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check("in_pwr", input_power, 8'h0a);
        check("out_pwr", output_power, 8'h00);
    endtask : t_chen
    task automatic t_unmapped;
        wr(7'h74, 8'hff);
        rd(7'h74);
        check("unmapped", rv, 8'h00);
        check("hit", reg_hit, 8'h00);
        clk_en = 1'b0;
        wr(7'h76, 8'h00);
        clk_en = 1'b1;
        rd(7'h76);
        check("frozen", rv, 8'h5a);
        check("hit", reg_hit, 8'h01);
    endtask : t_unmapped
    task automatic t_midreset;
        playback_power_on = 1'b1;
        record_power_on = 1'b1;
        @(negedge sys_clk);
        check("pre out_pwr", output_power, 8'h05);
        rst_n = 1'b0;
        @(negedge sys_clk);
        check("rst rdata", reg_rdata, 8'h00);
        check("rst in_pwr", input_power, 8'h00);
        check("rst out_pwr", output_power, 8'h00);
        check("rst in_en", input_enable, 8'h03);
        check("rst out_en", output_enable, 8'h03);
        rst_n = 1'b1;
        rd(7'h73);
        check("dsp", rv, 8'h18);
        check("out_pwr", output_power, 8'h03);
        check("in_pwr", input_power, 8'h03);
    endtask : t_midreset
    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, playback_power_on, record_power_on} = '0;
        clk_en = 1'b1;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        mismatches = 0;
        compares = 0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_dsp();
        t_both();
        t_chen();
        t_unmapped();
        t_midreset();
        results();
    end
endmodule : pdc_bank_test
`default_nettype wire
